// ### shared/i2c_target_pkg.sv
package i2c_target_pkg;

  // ----------------------------------------------------------------
  // Bus format
  // ----------------------------------------------------------------
  localparam int BYTE_BITS = 8;
  localparam int WORD_BITS = 16;
  localparam logic [2:0] BIT_CNT_LAST = 3'h7;
  localparam logic [2:0] BIT_CNT_ZERO = 3'h0;
  localparam logic DIR_READ = 1'b0;
  localparam logic DIR_WRITE = 1'b1;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ----------------------------------------------------------------
  // Device address
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_UPPER = 3'h6;
  localparam logic [6:0] ADDR_PIN_LOW = 7'h62;
  localparam logic [6:0] ADDR_PIN_HIGH = 7'h6A;

  // ----------------------------------------------------------------
  // Frequency update timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int FREQ_DELAY_US = 22;
  localparam int FREQ_SETTLE_US = 30;
  localparam int FREQ_DELAY_CYCLES = FREQ_DELAY_US * CLK_MHZ;
  localparam int FREQ_SETTLE_CYCLES = FREQ_SETTLE_US * CLK_MHZ;
  localparam logic [11:0] DELAY_CNT = 12'(FREQ_DELAY_CYCLES);
  localparam logic [11:0] SETTLE_CNT = 12'(FREQ_SETTLE_CYCLES);

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_PTR = 6'h04,
    ST_WRITE = 6'h08,
    ST_READ = 6'h10,
    ST_IGNORE = 6'h20
  } port_state_t;

  typedef enum logic [2:0] {
    FQ_QUIET = 3'h1,
    FQ_DELAY = 3'h2,
    FQ_SETTLE = 3'h4
  } freq_state_t;

endpackage : i2c_target_pkg

// ### hw/i2c_pin_sync.sv
`timescale 1ns/1ns
module i2c_pin_sync
  import i2c_target_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Pins
  input wire logic scl_in,
  input wire logic sda_in,
  // Synchronised levels and events
  output logic scl,
  output logic sda,
  output logic scl_rise,
  output logic scl_fall,
  output logic start_seen,
  output logic stop_seen
);

  typedef struct packed {
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic scl_q;
    logic sda_q;
    logic scl_old;
    logic sda_old;
  } sync_t;

  sync_t st;
  sync_t next_st;

  always_comb begin
    next_st = st;
    next_st.scl_meta = {st.scl_meta[0], scl_in};
    next_st.sda_meta = {st.sda_meta[0], sda_in};
    next_st.scl_q = st.scl_meta[1];
    next_st.sda_q = st.sda_meta[1];
    next_st.scl_old = st.scl_q;
    next_st.sda_old = st.sda_q;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '1;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign scl = st.scl_q;
  assign sda = st.sda_q;
  assign scl_rise = st.scl_q & ~st.scl_old;
  assign scl_fall = ~st.scl_q & st.scl_old;
  // Each bus phase must last several system clocks to be seen. [R21]
  // START and repeated START look alike: data falls while clock high.
  assign start_seen = st.scl_q & st.scl_old & st.sda_old & ~st.sda_q;
  assign stop_seen = st.scl_q & st.scl_old & ~st.sda_old & st.sda_q;

endmodule : i2c_pin_sync

// ### hw/freq_update_timer.sv
`timescale 1ns/1ns
module freq_update_timer
  import i2c_target_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Trigger
  input wire logic load,
  // Status
  output logic changing,
  output logic settled
);

  typedef struct packed {
    freq_state_t fsm;
    logic [11:0] cnt;
    logic chg;
    logic done;
  } timer_t;

  timer_t st;
  timer_t next_st;

  always_comb begin
    next_st = st;
    case (st.fsm)
      FQ_QUIET: begin
        next_st.chg = 1'b0;
      end
      FQ_DELAY: begin
        if (st.cnt == 12'h001) begin
          next_st.fsm = FQ_SETTLE;
          next_st.cnt = SETTLE_CNT - DELAY_CNT;
          next_st.chg = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 12'h001;
        end
      end
      FQ_SETTLE: begin
        if (st.cnt == 12'h001) begin
          next_st.fsm = FQ_QUIET;
          next_st.chg = 1'b0;
          next_st.done = 1'b1;
        end else begin
          next_st.cnt = st.cnt - 12'h001;
        end
      end
      default: begin
        next_st.fsm = FQ_QUIET;
      end
    endcase
    if (load) begin
      next_st.fsm = FQ_DELAY; // [R17]
      next_st.cnt = DELAY_CNT;
      next_st.chg = 1'b0;
      next_st.done = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{fsm: FQ_QUIET, cnt: 12'h000, chg: 1'b0, done: 1'b1};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign changing = st.chg;
  assign settled = st.done;

endmodule : freq_update_timer

// ### hw/i2c_register_target_port.sv
`timescale 1ns/1ns
// What this block does
// R1: Data line changes only while the clock is low, never while high.
// R2: One data-line change and one bit per clock low phase.
// R3: Only the controller makes START and STOP conditions.
// R4: Repeated START restarts the transaction without going idle.
// R5: Bytes are 8 bits, most significant bit first.
// R6: No limit on bytes between START and STOP.
// R7: Ninth pulse is acknowledge; low means acknowledge, high means not.
// R8: Not-acknowledge only a mismatched device address; acknowledge all else.
// R9: Controller acknowledges final read byte; target then releases data.
// R10: After read not-acknowledge, keep shifting the next byte out.
// R11: First byte is 7-bit address and direction; 0 read, 1 write.
// R12: Register pointer is one byte, range 0 to 255.
// R13: Pointer advances after each word and wraps 255 to 0.
// R14: Controller should use auto-advance only for writes.
// R15: Register words are 16 bits, high byte first.
// R16: Controller writes both frequency halves in one transaction.
// R17: Frequency starts changing 22 us after write, settles by 30 us.
// R18: Factory mode address is 110 plus 4-bit ordering code.
// R19: Pin mode uses the address-select pin to pick the address.
// R20: Pin mode: low answers 1100010, high answers 1101010.
// R21: Works with serial clock rates up to 1 MHz.
// R22: After address mismatch, stay released until next START.
module i2c_register_target_port
  import i2c_target_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  // Serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Address configuration
  input wire logic pin_address_mode,
  input wire logic [3:0] address_code,
  input wire logic address_select_pin,
  // Register file side
  output logic [7:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_write,
  output logic reg_read,
  input wire logic [15:0] reg_rdata,
  output logic [7:0] reg_pointer,
  // Frequency update status
  input wire logic freq_word_write,
  output logic freq_changing,
  output logic freq_settled
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    port_state_t fsm;
    logic [2:0] bit_cnt;
    logic ack_phase;
    logic [7:0] shift;
    logic [7:0] ptr;
    logic hi_byte;
    logic [7:0] hold_hi;
    logic [15:0] rd_word;
    logic drive_low;
    logic ack_out;
    logic master_nack;
    logic sel_pin;
    logic [7:0] wr_addr;
    logic [15:0] wdata;
    logic wr_pulse;
    logic rd_pulse;
  } port_t;

  port_t st;
  port_t next_st;

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [6:0] own_addr;
  logic [7:0] rx_byte;

  i2c_pin_sync u_sync (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl(scl),
    .sda(sda),
    .scl_rise(scl_rise),
    .scl_fall(scl_fall),
    .start_seen(start_seen),
    .stop_seen(stop_seen)
  );

  freq_update_timer u_timer (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(freq_word_write),
    .changing(freq_changing),
    .settled(freq_settled)
  );

  // ----------------------------------------------------------------
  // Own device address
  // ----------------------------------------------------------------
  always_comb begin
    if (pin_address_mode) begin
      own_addr = st.sel_pin ? ADDR_PIN_HIGH : ADDR_PIN_LOW; // [R19] [R20]
    end else begin
      own_addr = {ADDR_UPPER, address_code}; // [R18]
    end
  end

  // Bits arrive most significant first into the low end.
  assign rx_byte = {st.shift[6:0], sda}; // [R5]

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.wr_pulse = 1'b0;
    next_st.rd_pulse = 1'b0;
    // Sample the address-select pin only between transactions.
    if (st.fsm == ST_IDLE) begin
      next_st.sel_pin = address_select_pin;
    end
    if (start_seen) begin
      // Same handling for START and repeated START.
      next_st.fsm = ST_ADDR; // [R4]
      next_st.bit_cnt = BIT_CNT_ZERO;
      next_st.ack_phase = 1'b0;
      next_st.drive_low = 1'b0;
      next_st.hi_byte = 1'b1;
    end else if (stop_seen) begin
      next_st.fsm = ST_IDLE;
      next_st.drive_low = 1'b0;
    end else if (scl_rise && !st.ack_phase) begin
      // Data is sampled on the rising edge while it must be stable.
      next_st.shift = rx_byte; // [R1]
      if (st.bit_cnt == BIT_CNT_LAST) begin
        next_st.ack_phase = 1'b1;
        next_st.bit_cnt = BIT_CNT_ZERO;
        case (st.fsm)
          ST_ADDR: begin
            next_st.ack_out = (rx_byte[7:1] == own_addr); // [R8]
            next_st.hi_byte = 1'b1;
          end
          ST_PTR: begin
            next_st.ptr = rx_byte; // [R12]
            next_st.ack_out = 1'b1;
          end
          ST_WRITE: begin
            next_st.ack_out = 1'b1; // [R8]
            if (st.hi_byte) begin
              next_st.hold_hi = rx_byte; // [R15]
            end else begin
              next_st.wdata = {st.hold_hi, rx_byte};
              next_st.wr_addr = st.ptr;
              next_st.wr_pulse = 1'b1;
              next_st.ptr = st.ptr + PTR_STEP; // [R13]
            end
            next_st.hi_byte = ~st.hi_byte;
          end
          default: begin
            next_st.ack_out = 1'b0;
          end
        endcase
      end else begin
        next_st.bit_cnt = st.bit_cnt + 3'h1;
      end
    end else if (scl_rise && st.ack_phase) begin
      // Ninth pulse: in a read the controller answers here.
      next_st.master_nack = sda; // [R7]
    end else if (scl_fall) begin
      // All data-line changes happen just after the clock falls.
      if (st.ack_phase && st.bit_cnt == BIT_CNT_ZERO && st.fsm != ST_READ
          && !st.drive_low && st.fsm != ST_IGNORE && st.fsm != ST_IDLE) begin
        // Start of the acknowledge slot.
        next_st.drive_low = st.ack_out; // [R7] [R2]
        if (st.fsm == ST_ADDR && !st.ack_out) begin
          next_st.fsm = ST_IGNORE; // [R22]
          next_st.ack_phase = 1'b0;
        end
      end else if (st.ack_phase) begin
        // End of the acknowledge slot.
        next_st.ack_phase = 1'b0;
        next_st.drive_low = 1'b0;
        case (st.fsm)
          ST_ADDR: begin
            if (st.shift[0] == DIR_WRITE) begin // [R11]
              next_st.fsm = ST_PTR;
            end else begin
              next_st.fsm = ST_READ;
              next_st.rd_word = reg_rdata;
              next_st.hi_byte = 1'b1;
              next_st.rd_pulse = 1'b1;
              next_st.drive_low = ~reg_rdata[WORD_BITS-1];
              next_st.shift = reg_rdata[15:8];
            end
          end
          ST_PTR: begin
            next_st.fsm = ST_WRITE; // [R6]
            next_st.hi_byte = 1'b1;
          end
          ST_READ: begin
            // An acknowledge marks the final byte: release the line so
            // that the controller can end the transfer. After a
            // not-acknowledge the next byte goes out.
            if (!st.master_nack) begin
              next_st.fsm = ST_IGNORE; // [R9]
              next_st.drive_low = 1'b0;
            end else if (st.hi_byte) begin
              next_st.shift = st.rd_word[7:0]; // [R15]
              next_st.drive_low = ~st.rd_word[7];
              next_st.hi_byte = 1'b0;
              // Step now, so the next fetch already sees the new address.
              next_st.ptr = st.ptr + PTR_STEP; // [R13]
            end else begin
              next_st.rd_word = reg_rdata;
              next_st.rd_pulse = 1'b1;
              next_st.shift = reg_rdata[15:8];
              next_st.drive_low = ~reg_rdata[WORD_BITS-1]; // [R10]
              next_st.hi_byte = 1'b1;
            end
          end
          default: begin
            next_st.drive_low = 1'b0;
          end
        endcase
      end else if (st.fsm == ST_READ) begin
        // Shift out one bit per low phase of the clock.
        if (st.bit_cnt == BIT_CNT_LAST) begin
          next_st.bit_cnt = BIT_CNT_ZERO;
          next_st.ack_phase = 1'b1;
          next_st.drive_low = 1'b0; // [R9]
        end else begin
          next_st.bit_cnt = st.bit_cnt + 3'h1;
          next_st.shift = {st.shift[6:0], 1'b0};
          next_st.drive_low = ~st.shift[6]; // [R1] [R2]
        end
      end
    end
    if (st.fsm == ST_READ && scl_rise && !st.ack_phase
        && st.bit_cnt != BIT_CNT_LAST) begin
      // Keep the transmit byte; the receive path must not clobber it.
      next_st.shift = st.shift;
      next_st.bit_cnt = st.bit_cnt;
    end else if (st.fsm == ST_READ && scl_rise && !st.ack_phase) begin
      next_st.shift = st.shift;
      next_st.bit_cnt = st.bit_cnt;
      next_st.ack_phase = 1'b0;
    end
  end

  // Read bit counter moves on the falling edge, so undo the rise path.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{fsm: ST_IDLE, bit_cnt: 3'h0, ack_phase: 1'b0,
              shift: 8'h00, ptr: PTR_RESET, hi_byte: 1'b1,
              hold_hi: 8'h00, rd_word: 16'h0000, drive_low: 1'b0,
              ack_out: 1'b0, master_nack: 1'b0, sel_pin: 1'b0,
              wr_addr: 8'h00, wdata: 16'h0000, wr_pulse: 1'b0,
              rd_pulse: 1'b0};
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign sda_out = 1'b0;
  assign sda_oe = st.drive_low;
  // The first read word is fetched while the address byte closes, so
  // the pointer must already be on the bus in that state.
  assign reg_addr = (st.fsm == ST_READ || st.fsm == ST_ADDR) ? st.ptr
                    : st.wr_addr;
  assign reg_wdata = st.wdata;
  assign reg_write = st.wr_pulse;
  assign reg_read = st.rd_pulse;
  assign reg_pointer = st.ptr;

endmodule : i2c_register_target_port

// ### test/i2c_target_asserts.sv
`timescale 1ns/1ns
module i2c_target_asserts (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Serial bus
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  // Register side
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_pointer,
  // Frequency timer
  input wire logic freq_word_write,
  input wire logic freq_changing,
  input wire logic freq_settled
);
  // ----------------------------------------
  // Cycles since the last frequency load
  // ----------------------------------------
  logic [12:0] age;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      age <= 13'h1FFF;
    end else if (freq_word_write) begin
      age <= 13'h0000;
    end else if (age != 13'h1FFF) begin
      age <= age + 13'h0001;
    end
  end
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  sda_out_zero_a: assert property (sda_out == 1'b0)
    else $error("sda_out is not zero");
  oe_low_phase_a: assert property ($changed(sda_oe) |-> !$past(scl_in, 2))
    else $error("sda_oe changed while clock high");
  oe_one_change_a: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*6])
    else $error("sda_oe changed twice in one phase");
  wr_ptr_step_a: assert property (reg_write |-> ##[1:2]
    (reg_pointer == reg_addr + 8'h01))
    else $error("pointer did not step after write");
  wr_pulse_a: assert property (reg_write |=> !reg_write)
    else $error("write pulse longer than one cycle");
  stop_release_a: assert property (($rose(sda_in) && scl_in && $past(scl_in))
    |=> !sda_oe [*8])
    else $error("data line driven after stop");
  freq_load_a: assert property (freq_word_write |-> ##[1:2] !freq_settled)
    else $error("settled still high after load");
  freq_delay_a: assert property ($rose(freq_changing) |->
    (age >= 13'd2197 && age <= 13'd2203))
    else $error("frequency change delay wrong");
  freq_settle_a: assert property ($rose(freq_settled) |->
    (age >= 13'd2997 && age <= 13'd3003))
    else $error("frequency settle time wrong");
  cover property (reg_write);
  cover property ($rose(freq_settled));
  cover property ($rose(sda_oe) && !scl_in);
endmodule : i2c_target_asserts

bind i2c_register_target_port i2c_target_asserts i_chk (
  .clk_sys(clk_sys), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .reg_addr(reg_addr),
  .reg_write(reg_write), .reg_pointer(reg_pointer),
  .freq_word_write(freq_word_write), .freq_changing(freq_changing),
  .freq_settled(freq_settled));

// ### test/i2c_controller_model.sv
`timescale 1ns/1ns
module i2c_controller_model (
  // Bus lines
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // Both lines idle released; the clock stands high between frames.
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // Data moves mid-low, is sampled at the end of the high phase.
  task automatic bit_io(input logic b, output logic s);
    #20 sda_low = !b;
    #30 scl = 1'b1;
    #30 s = sda_line;
    scl = 1'b0;
  endtask : bit_io
  task automatic start();
    #3;
    if (!scl) begin
      #20 sda_low = 1'b0;
      #30 scl = 1'b1;
    end
    #20 sda_low = 1'b1;
    #30 scl = 1'b0;
  endtask : start
  task automatic stop();
    #20 sda_low = 1'b1;
    #30 scl = 1'b1;
    #20 sda_low = 1'b0;
    #30;
  endtask : stop
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, s);
    ack = !s;
  endtask : wr_byte
  task automatic rd_byte(input logic ack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      b[i] = s;
    end
    bit_io(!ack, s);
  endtask : rd_byte
endmodule : i2c_controller_model

// ### test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  logic clk_sys, reset_n, clk_en, pin_address_mode, address_select_pin;
  logic freq_word_write, sda_out, sda_oe, reg_write, reg_read;
  logic freq_changing, freq_settled, scl, sda_low, sda_line;
  logic [3:0] address_code;
  logic [7:0] reg_addr, reg_pointer;
  logic [15:0] reg_rdata, reg_wdata;
  logic [23:0] wq[$];
  int err_total, checked;
  int rd_cnt;
  assign sda_line = !((sda_oe && !sda_out) || sda_low);
  assign reg_rdata = {reg_addr, ~reg_addr};
  i2c_register_target_port i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .pin_address_mode(pin_address_mode), .address_code(address_code),
    .address_select_pin(address_select_pin), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_pointer(reg_pointer),
    .freq_word_write(freq_word_write), .freq_changing(freq_changing),
    .freq_settled(freq_settled));
  i2c_controller_model i_ctl (.scl(scl), .sda_low(sda_low),
    .sda_line(sda_line));
  always @(posedge clk_sys) begin
    if (reg_write === 1'b1) wq.push_back({reg_addr, reg_wdata});
    if (reg_read === 1'b1) rd_cnt++;
  end
  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task check(input string what, input logic [23:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task end_sim();
    $display("mismatches %0d checks %0d", err_total, checked);
    if (err_total == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim
  task tick();
    @(posedge clk_sys);
    #1;
  endtask : tick
  task probe(input logic [6:0] ad, input logic exp);
    logic a;
    i_ctl.start();
    i_ctl.wr_byte({ad, 1'b1}, a);
    i_ctl.stop();
    check("address ack", 24'(a), 24'(exp));
  endtask : probe
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task s_write();
    logic a;
    logic [15:0] w[3];
    w = '{16'h1234, 16'hABCD, 16'h5A5A};
    wq.delete();
    i_ctl.start();
    i_ctl.wr_byte({7'h65, 1'b1}, a);
    check("write addr ack", 24'(a), 24'h1);
    i_ctl.wr_byte(8'hFE, a);
    check("pointer ack", 24'(a), 24'h1);
    for (int k = 0; k < 3; k++) begin
      i_ctl.wr_byte(w[k][15:8], a);
      check("high ack", 24'(a), 24'h1);
      i_ctl.wr_byte(w[k][7:0], a);
      check("low ack", 24'(a), 24'h1);
    end
    i_ctl.stop();
    repeat (4) tick();
    check("write count", 24'(wq.size()), 24'h3);
    for (int k = 0; k < 3 && k < wq.size(); k++) begin
      check("word", wq[k], {8'(8'hFE + k), w[k]});
    end
    check("pointer", 24'(reg_pointer), 24'h1);
  endtask : s_write
  task s_mismatch();
    logic a;
    i_ctl.start();
    i_ctl.wr_byte({7'h66, 1'b1}, a);
    check("foreign ack", 24'(a), 24'h0);
    i_ctl.wr_byte(8'h00, a);
    check("ignored ack", 24'(a), 24'h0);
    i_ctl.start();
    i_ctl.wr_byte({7'h65, 1'b1}, a);
    check("restart ack", 24'(a), 24'h1);
    i_ctl.stop();
  endtask : s_mismatch
  task s_read();
    logic a;
    logic [7:0] b;
    rd_cnt = 0;
    i_ctl.start();
    i_ctl.wr_byte({7'h65, 1'b1}, a);
    i_ctl.wr_byte(8'h10, a);
    i_ctl.start();
    i_ctl.wr_byte({7'h65, 1'b0}, a);
    check("read addr ack", 24'(a), 24'h1);
    i_ctl.rd_byte(1'b0, b);
    check("read high", 24'(b), 24'h10);
    i_ctl.rd_byte(1'b0, b);
    check("read low", 24'(b), 24'hEF);
    i_ctl.rd_byte(1'b0, b);
    check("after nack", 24'(b), 24'h11);
    i_ctl.rd_byte(1'b1, b);
    check("last low", 24'(b), 24'hEE);
    i_ctl.stop();
    check("line idle", 24'(sda_line), 24'h1);
    check("read fetches", 24'(rd_cnt), 24'h2);
  endtask : s_read
  task s_address();
    logic [6:0] pin_ad[3];
    pin_ad = '{7'h62, 7'h6A, 7'h6F};
    for (int c = 0; c < 16; c++) begin
      address_code = 4'(c);
      probe({3'h6, 4'(c)}, 1'b1);
      probe({3'h6, 4'(c ^ 1)}, 1'b0);
    end
    pin_address_mode = 1'b1;
    for (int s = 0; s < 2; s++) begin
      address_select_pin = 1'(s);
      repeat (4) tick();
      for (int t = 0; t < 3; t++) probe(pin_ad[t], 1'(s == t));
    end
    pin_address_mode = 1'b0;
    address_code = 4'h5;
  endtask : s_address
  task s_freq();
    int n;
    check("settled at reset", 24'(freq_settled), 24'h1);
    tick();
    freq_word_write = 1'b1;
    tick();
    freq_word_write = 1'b0;
    tick();
    check("settled after load", 24'(freq_settled), 24'h0);
    n = 2;
    while (freq_changing !== 1'b1 && n < 4000) begin
      tick();
      n++;
    end
    check("delay ok", 24'(n >= 2195 && n <= 2205), 24'h1);
    while (freq_settled !== 1'b1 && n < 4000) begin
      tick();
      n++;
    end
    check("settle ok", 24'(n >= 2995 && n <= 3005), 24'h1);
    if (n >= 4000) end_sim();
  endtask : s_freq
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = !clk_sys;
  end
  initial begin
    err_total = 0;
    checked = 0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    pin_address_mode = 1'b0;
    address_select_pin = 1'b0;
    address_code = 4'h5;
    freq_word_write = 1'b0;
    repeat (12) tick();
    reset_n = 1'b1;
    repeat (4) tick();
    check("pointer at reset", 24'(reg_pointer), 24'h0);
    s_write();
    s_mismatch();
    s_read();
    s_address();
    s_freq();
    end_sim();
  end
endmodule : tb_top
